// ### design/dtc_pkg.sv
// Constants and types shared by the transmit serializer and correlator block
package dtc_pkg;
    // Register offsets on the serial host port
    localparam logic [5:0] ADDR_CTRL      = 6'h03;
    localparam logic [5:0] ADDR_TX_IEN    = 6'h0D;
    localparam logic [5:0] ADDR_TX_STAT   = 6'h0E;
    localparam logic [5:0] ADDR_TX_DATA   = 6'h0F;
    localparam logic [5:0] ADDR_TX_VALID  = 6'h10;
    localparam logic [5:0] ADDR_CODE_BASE = 6'h11;
    localparam logic [5:0] ADDR_THR_LOW   = 6'h19;
    localparam logic [5:0] ADDR_THR_HIGH  = 6'h1A;
    // Control register fields
    localparam int CTRL_TX_EN_BIT  = 7;
    localparam int CTRL_RX_EN_BIT  = 6;
    localparam int CTRL_HALF_BIT   = 5;
    localparam int CTRL_UPPER_BIT  = 4;
    // Transmit status fields
    localparam int STAT_EMPTY_BIT  = 0;
    localparam int STAT_DONE_BIT   = 1;
    localparam int STAT_OVF_BIT    = 2;
    localparam int STAT_UNF_BIT    = 3;
    // Reset values
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic [7:0]  TX_IEN_RST    = 8'h00;
    localparam logic [7:0]  TX_DATA_RST   = 8'h00;
    localparam logic [7:0]  TX_VALID_RST  = 8'h00;
    localparam logic [7:0]  CODE_BYTE_RST = 8'h00;
    localparam logic [6:0]  THR_LOW_RST   = 7'h08;
    localparam logic [6:0]  THR_HIGH_RST  = 7'h38;
    // Code geometry
    localparam int CODE_BYTES = 8;
    localparam logic [5:0] CHIPS_FULL_LAST = 6'h3F;
    localparam logic [5:0] CHIPS_HALF_LAST = 6'h1F;
    // Chip timing
    localparam int SYS_CLK_HZ   = 25000000;
    localparam int CHIP_RATE_HZ = 1000000;
    localparam int CHIP_CYCLES  = SYS_CLK_HZ / CHIP_RATE_HZ;
    localparam logic [4:0] CHIP_DIV_LAST = 5'(CHIP_CYCLES - 1);
    // Serial host port pins
    typedef struct packed {
        logic sck;
        logic mosi;
        logic csN;
    } dtc_spi_s;
    // Correlator decision
    typedef struct packed {
        logic valid;
        logic value;
        logic erasure;
    } dtc_rx_bit_s;
endpackage

// ### design/dtc_tx_serdes_corr.sv
// Transmit serializer, spreading code store and correlator with serial host port
`timescale 1ns/1ps
module dtc_tx_serdes_corr
    import dtc_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire dtc_pkg::dtc_spi_s    spiIn,
    output logic                      spiMiso,
    input  wire logic                 rxChipIn,
    output logic                      txChip,
    output logic                      txActive,
    output dtc_pkg::dtc_rx_bit_s      rxBit
);
    import dtc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic       csS1, csS2, sckS1, sckS2, sckS3, mosiS1, mosiS2, rxS1, rxS2;
    logic       sckRise, sckFall;

    // Two flops on every pin input, a third on the clock for edge detection
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            csS1   <= 1'b1;
            csS2   <= 1'b1;
            sckS1  <= 1'b0;
            sckS2  <= 1'b0;
            sckS3  <= 1'b0;
            mosiS1 <= 1'b0;
            mosiS2 <= 1'b0;
            rxS1   <= 1'b0;
            rxS2   <= 1'b0;
        end else begin
            csS1   <= spiIn.csN;
            csS2   <= csS1;
            sckS1  <= spiIn.sck;
            sckS2  <= sckS1;
            sckS3  <= sckS2;
            mosiS1 <= spiIn.mosi;
            mosiS2 <= mosiS1;
            rxS1   <= rxChipIn;
            rxS2   <= rxS1;
        end
    end

    assign sckRise = sckS2 & ~sckS3 & ~csS2;
    assign sckFall = ~sckS2 & sckS3 & ~csS2;

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  ctrl_reg, txIen_reg, txData_reg, txValid_reg;
    logic [6:0]  thrLow_reg, thrHigh_reg;
    logic [7:0]  codeByte [CODE_BYTES];
    logic [63:0] code;
    logic        empty_reg, done_reg, ovf_reg, unf_reg;
    logic        txEn, rxEn, halfMode, upperHalf;
    logic        wrStb, rdStb;
    logic [5:0]  addr_reg;
    logic [7:0]  wrData;

    assign txEn      = ctrl_reg[CTRL_TX_EN_BIT];
    assign rxEn      = ctrl_reg[CTRL_RX_EN_BIT];
    assign halfMode  = ctrl_reg[CTRL_HALF_BIT];
    assign upperHalf = ctrl_reg[CTRL_UPPER_BIT];

    // Code bytes, byte 0 holds chips 7:0
    for (genvar i = 0; i < CODE_BYTES; i++) begin : gCode
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                codeByte[i] <= CODE_BYTE_RST;
            end else if (wrStb && addr_reg == ADDR_CODE_BASE + 6'(i)) begin
                codeByte[i] <= wrData;
            end
        end
        assign code[8*i +: 8] = codeByte[i];
    end

    // Plain read-write registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_reg    <= CTRL_RST;
            txIen_reg   <= TX_IEN_RST;
            txData_reg  <= TX_DATA_RST;
            txValid_reg <= TX_VALID_RST;
            thrLow_reg  <= THR_LOW_RST;
            thrHigh_reg <= THR_HIGH_RST;
        end else if (wrStb) begin
            unique case (addr_reg)
                ADDR_CTRL:     ctrl_reg    <= wrData;
                ADDR_TX_IEN:   txIen_reg   <= wrData;
                ADDR_TX_DATA:  txData_reg  <= wrData;
                ADDR_TX_VALID: txValid_reg <= wrData;
                ADDR_THR_LOW:  thrLow_reg  <= wrData[6:0];
                ADDR_THR_HIGH: thrHigh_reg <= wrData[6:0];
                default: ;
            endcase
        end
    end

    // Read data, status masked by transmit enable
    function automatic logic [7:0] readMux(input logic [5:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == ADDR_CTRL)     r = ctrl_reg;
        if (a == ADDR_TX_IEN)   r = txIen_reg;
        if (a == ADDR_TX_STAT)  r = {4'h0, unf_reg, ovf_reg, done_reg, empty_reg}
                                    & {8{txEn}};
        if (a == ADDR_TX_DATA)  r = txData_reg;
        if (a == ADDR_TX_VALID) r = txValid_reg;
        if (a == ADDR_THR_LOW)  r = {1'b0, thrLow_reg};
        if (a == ADDR_THR_HIGH) r = {1'b0, thrHigh_reg};
        if (a >= ADDR_CODE_BASE && a < ADDR_THR_LOW) r = codeByte[3'(a - ADDR_CODE_BASE)];
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Serial host port slave: command byte then data byte, MSB first
    logic [3:0] bitCnt_reg;
    logic [7:0] shIn_reg, misoSh_reg;
    logic       isWrite_reg;
    logic [7:0] inNext;

    assign inNext = {shIn_reg[6:0], mosiS2};
    assign wrStb  = sckRise && bitCnt_reg == 4'hF && isWrite_reg;
    assign rdStb  = sckRise && bitCnt_reg == 4'h7 && !inNext[7];
    assign wrData = inNext;

    // Frame bit counter and command decode
    always_ff @(posedge sys_clk) begin
        if (rst || csS2) begin
            bitCnt_reg  <= 4'h0;
            shIn_reg    <= 8'h00;
            isWrite_reg <= 1'b0;
            addr_reg    <= 6'h00;
        end else if (sckRise) begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
            shIn_reg   <= inNext;
            if (bitCnt_reg == 4'h7) begin
                isWrite_reg <= inNext[7];
                addr_reg    <= inNext[5:0];
            end
        end
    end

    // Read data shifted out on falling edges
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            misoSh_reg <= 8'h00;
            spiMiso    <= 1'b0;
        end else if (rdStb) begin
            misoSh_reg <= readMux(inNext[5:0]);
        end else if (sckFall) begin
            spiMiso    <= misoSh_reg[7];
            misoSh_reg <= {misoSh_reg[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Chip timing
    logic [4:0] div_reg;
    logic       chipStb, load;
    logic [5:0] chipIdx_reg, corrIdx_reg, chipLast;
    logic       bitEnd;

    assign chipStb  = div_reg == CHIP_DIV_LAST;
    assign chipLast = halfMode ? CHIPS_HALF_LAST : CHIPS_FULL_LAST;

    // Chip rate divider, restarted when an idle transmitter starts so chip 0 is whole
    always_ff @(posedge sys_clk) begin
        if (rst || chipStb || (load && !txActive)) begin
            div_reg <= 5'h00;
        end else begin
            div_reg <= div_reg + 5'h01;
        end
    end

    // Code chip selection with optional upper half
    function automatic logic codeChip(input logic [5:0] idx);
        logic [5:0] k;
        k = (halfMode && upperHalf) ? {1'b1, idx[4:0]} : idx;
        return code[k];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit serializer
    logic [7:0] shData_reg, shValid_reg;
    logic       pend_reg, sent_reg, needData, lastBit;

    // Next byte follows the last valid bit with no gap
    assign bitEnd   = chipStb && chipIdx_reg == chipLast;
    assign lastBit  = bitEnd && shValid_reg[7:1] == 7'h00;
    assign needData = txEn && (lastBit || (shValid_reg == 8'h00 && !txActive));
    assign load     = needData && pend_reg;

    // Chip index within a bit, counts up from zero
    always_ff @(posedge sys_clk) begin
        if (rst || !txActive || bitEnd) begin
            chipIdx_reg <= 6'h00;
        end else if (chipStb) begin
            chipIdx_reg <= chipIdx_reg + 6'h01;
        end
    end

    // Shifter load and shift per bit time
    always_ff @(posedge sys_clk) begin
        if (rst || !txEn) begin
            shData_reg  <= 8'h00;
            shValid_reg <= 8'h00;
        end else if (load) begin
            shData_reg  <= txData_reg;
            shValid_reg <= txValid_reg;
        end else if (bitEnd) begin
            shData_reg  <= {1'b0, shData_reg[7:1]};
            shValid_reg <= {1'b0, shValid_reg[7:1]};
        end
    end

    // Chip output, data spread or preamble
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            txChip   <= 1'b0;
            txActive <= 1'b0;
        end else begin
            txActive <= txEn && (load || (shValid_reg != 8'h00 && !(bitEnd &&
                        shValid_reg[7:1] == 7'h00)));
            if (!shValid_reg[0]) begin
                txChip <= codeChip(chipIdx_reg);
            end else begin
                txChip <= codeChip(chipIdx_reg) ~^ shData_reg[0];
            end
        end
    end

    // Pending byte and at-least-one-bit tracking
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend_reg <= 1'b0;
            sent_reg <= 1'b0;
        end else begin
            if (wrStb && addr_reg == ADDR_TX_DATA) begin
                pend_reg <= 1'b1;
            end else if (load) begin
                pend_reg <= 1'b0;
            end
            if (load) begin
                sent_reg <= 1'b1;
            end else if (needData && bitEnd) begin
                sent_reg <= 1'b0;
            end
        end
    end

    // Sticky status flags, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            empty_reg <= 1'b0;
            done_reg  <= 1'b0;
            ovf_reg   <= 1'b0;
            unf_reg   <= 1'b0;
        end else begin
            if (load) begin
                empty_reg <= 1'b1;
            end else if (wrStb && addr_reg == ADDR_TX_DATA) begin
                empty_reg <= 1'b0;
            end
            if (needData && bitEnd && !pend_reg && sent_reg) begin
                done_reg <= 1'b1;
            end else if (rdStb && inNext[5:0] == ADDR_TX_STAT) begin
                done_reg <= 1'b0;
            end
            if (wrStb && addr_reg == ADDR_TX_DATA && pend_reg) begin
                ovf_reg <= 1'b1;
            end else if (rdStb && inNext[5:0] == ADDR_TX_STAT) begin
                ovf_reg <= 1'b0;
            end
            if (needData && bitEnd && !pend_reg && !sent_reg) begin
                unf_reg <= 1'b1;
            end else if (rdStb && inNext[5:0] == ADDR_TX_STAT) begin
                unf_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Correlator
    logic [6:0] match_reg, matchNext;
    logic       corrEnd;

    assign corrEnd   = chipStb && corrIdx_reg == chipLast;
    assign matchNext = match_reg + 7'((rxS2 == codeChip(corrIdx_reg)) ? 1 : 0);

    // Match count over one bit window
    always_ff @(posedge sys_clk) begin
        if (rst || !rxEn) begin
            corrIdx_reg <= 6'h00;
            match_reg   <= 7'h00;
        end else if (corrEnd) begin
            corrIdx_reg <= 6'h00;
            match_reg   <= 7'h00;
        end else if (chipStb) begin
            corrIdx_reg <= corrIdx_reg + 6'h01;
            match_reg   <= matchNext;
        end
    end

    // Bit decision against thresholds
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rxBit <= '0;
        end else begin
            rxBit.valid <= rxEn && corrEnd;
            if (rxEn && corrEnd) begin
                rxBit.value   <= matchNext >= thrHigh_reg;
                rxBit.erasure <= matchNext > thrLow_reg && matchNext < thrHigh_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_status_gated: assert property (rdStb && inNext[5:0] == ADDR_TX_STAT && !txEn |=>
        misoSh_reg == 8'h00) else $error("status visible while tx off");
    a_empty_set: assert property (load |=> empty_reg) else $error("empty not set on load");
    a_empty_clr: assert property (wrStb && addr_reg == ADDR_TX_DATA && !load |=>
        !empty_reg) else $error("empty not cleared by data write");
    a_load_pair: assert property (load |=>
        shValid_reg == $past(txValid_reg) && shData_reg == $past(txData_reg))
        else $error("data and mask not loaded together");
    a_shift_lsb: assert property (bitEnd && !load && txEn |=>
        shData_reg == {1'b0, $past(shData_reg[7:1])}) else $error("shift not lsb first");
    a_no_early_load: assert property (shValid_reg != 8'h00 && !bitEnd |-> !load)
        else $error("load before valid bits sent");
    a_thr_reset: assert property ($fell(rst) |->
        thrLow_reg == 7'h08 && thrHigh_reg == 7'h38) else $error("threshold reset value wrong");
    a_dec_one: assert property (rxEn && corrEnd && matchNext >= thrHigh_reg |=>
        rxBit.value) else $error("one decision missed");
    a_dec_zero: assert property (rxEn && corrEnd && matchNext <= thrLow_reg |=>
        !rxBit.value && !rxBit.erasure) else $error("zero decision missed");
    a_chip_order: assert property (chipStb && txActive && !bitEnd |=>
        chipIdx_reg == $past(chipIdx_reg) + 6'h01) else $error("chip order wrong");
    a_ovf_set: assert property (wrStb && addr_reg == ADDR_TX_DATA && pend_reg |=>
        ovf_reg) else $error("overflow not flagged");

    c_load: cover property (load);
    c_done: cover property ($rose(done_reg));
    c_rx_one: cover property (rxBit.valid && rxBit.value);
    c_half: cover property (halfMode && bitEnd);
endmodule

// ### test/dtc_host_model.sv
// Host controller model that drives the serial host port
`timescale 1ns/1ps
module dtc_host_model
    import dtc_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         spiMiso,
    output dtc_pkg::dtc_spi_s spiOut
);
    ////////////////////////////////////////////////////////////
    // Idle port at time zero, clock low for mode 0
    initial begin
        spiOut = '{sck: 1'b0, mosi: 1'b1, csN: 1'b1};
    end

    // Wait whole system cycles on the falling edge
    task automatic waitN(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////
    // One access: command byte then data byte, MSB first
    task automatic xfer(input logic wr, input logic [5:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] frame;
        logic [7:0]  wd;
        wd = wdata;
        if (wr && (addr == ADDR_THR_LOW || addr == ADDR_THR_HIGH)) begin
            wd[7] = 1'b0;
        end
        frame = {wr, 1'b0, addr, wd};
        rdata = 8'h00;
        spiOut.csN = 1'b0;
        waitN(6);
        // Each clock level lasts 6 system cycles, slow enough to sync
        for (int i = 15; i >= 0; i--) begin
            spiOut.mosi = frame[i];
            waitN(6);
            spiOut.sck = 1'b1;
            if (i < 8) begin
                rdata[i] = spiMiso;
            end
            waitN(6);
            spiOut.sck = 1'b0;
        end
        waitN(6);
        spiOut.csN = 1'b1;
        spiOut.mosi = ~spiOut.mosi; // Released line never shows last bit
        waitN(6);
    endtask
endmodule

// ### test/dtc_tx_serdes_corr_bench.sv
// Self-checking bench for the transmit serializer and correlator
`timescale 1ns/1ps
module dtc_tx_serdes_corr_bench;
    import dtc_pkg::*;
    localparam logic [5:0] R_ADDR [9] = '{ADDR_CTRL, ADDR_TX_IEN, ADDR_TX_STAT,
        ADDR_TX_DATA, ADDR_TX_VALID, ADDR_CODE_BASE, ADDR_THR_LOW, ADDR_THR_HIGH, 6'h3F};
    localparam logic [7:0] R_RST [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h08, 8'h38, 8'h00};
    localparam logic [5:0] W_ADDR [3] = '{ADDR_THR_LOW, ADDR_THR_HIGH, 6'h3F};
    localparam logic [7:0] W_DATA [3] = '{8'hFF, 8'h41, 8'hFF};
    localparam logic [7:0] W_EXP [3]  = '{8'h7F, 8'h41, 8'h00};
    localparam logic [7:0] T_LOW [4]  = '{8'h08, 8'h08, 8'h20, 8'h1F};
    localparam logic [7:0] T_HIGH [4] = '{8'h38, 8'h20, 8'h30, 8'h21};
    localparam logic [3:0] T_VAL      = 4'h2;
    localparam logic [3:0] T_ERA      = 4'h9;
    localparam logic [63:0] TX_CODE   = 64'h3C5A_96E1_0F87_D24B;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        rxChipIn = 1'b0;
    dtc_spi_s    spiIn;
    logic        spiMiso;
    logic        txChip;
    logic        txActive;
    dtc_rx_bit_s rxBit;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    ////////////////////////////////////////////////////////////
    // Device and host model
    dtc_tx_serdes_corr u_dut (.sys_clk(sys_clk), .rst(rst), .spiIn(spiIn),
        .spiMiso(spiMiso), .rxChipIn(rxChipIn), .txChip(txChip),
        .txActive(txActive), .rxBit(rxBit));
    dtc_host_model u_host (.sys_clk(sys_clk), .spiMiso(spiMiso), .spiOut(spiIn));

    // 25 MHz system clock
    always #20 sys_clk = ~sys_clk;

    // Cycle ceiling against hangs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 80000) begin
            bad_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////
    // Comparisons and verdict
    task automatic chkByte(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkBit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %b seen %b at %0t", nm, e, g, $time);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Register access through the host port
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_host.xfer(1'b1, a, d, r);
    endtask

    task automatic rdChk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e,
                         input string nm);
        logic [7:0] r;
        u_host.xfer(1'b0, a, 8'h00, r);
        chkByte(nm, e, r & m);
    endtask

    // Chip stream check, sampled mid-chip after the shifter starts
    task automatic checkTx(input logic [7:0] d, input logic [7:0] v, input int nb,
                           input int chips, input int base);
        int   n;
        logic e;
        n = 0;
        while (txActive !== 1'b1 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        repeat (12) @(negedge sys_clk);
        for (int b = 0; b < nb; b++) begin
            for (int c = 0; c < chips; c++) begin
                e = v[b] ? ~(TX_CODE[base + c] ^ d[b]) : TX_CODE[base + c];
                chkBit("txChip", e, txChip);
                repeat (25) @(negedge sys_clk);
            end
        end
    endtask

    // Correlator decision on the second window after a change
    task automatic rxCheck(input logic val, input logic era);
        int n;
        int k;
        n = 0;
        k = 0;
        while (k < 2 && n < 5000) begin
            @(negedge sys_clk);
            n++;
            if (rxBit.valid === 1'b1) k++;
        end
        chkBit("rxValid", 1'b1, rxBit.valid);
        chkBit("rxValue", val, rxBit.value);
        chkBit("rxErasure", era, rxBit.erasure);
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        for (int i = 0; i < 9; i++) begin
            rdChk(R_ADDR[i], 8'hFF, R_RST[i], "resetVal");
        end
        for (int i = 0; i < 3; i++) begin
            wr(W_ADDR[i], W_DATA[i]);
            rdChk(W_ADDR[i], 8'hFF, W_EXP[i], "readBack");
        end
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CODE_BASE + 6'(i), TX_CODE[8 * i +: 8]);
        end
        rdChk(ADDR_CODE_BASE + 6'h07, 8'hFF, TX_CODE[63:56], "codeTop");
        // Two bytes back to back, one bit invalid in each
        wr(ADDR_TX_VALID, 8'h0D);
        wr(ADDR_TX_DATA, 8'hA5);
        rdChk(ADDR_TX_STAT, 8'hFF, 8'h00, "statOff");
        fork
            checkTx(8'hA5, 8'hDD, 8, 64, 0);
            begin
                wr(ADDR_CTRL, 8'h80);
                rdChk(ADDR_TX_STAT, 8'h05, 8'h01, "empty");
                wr(ADDR_TX_DATA, 8'h3C);
                rdChk(ADDR_TX_STAT, 8'h05, 8'h00, "pending");
                wr(ADDR_TX_DATA, 8'h5A);
                rdChk(ADDR_TX_STAT, 8'h05, 8'h04, "overflow");
            end
        join
        repeat (5) @(negedge sys_clk);
        chkBit("txActive", 1'b0, txActive);
        rdChk(ADDR_TX_STAT, 8'h03, 8'h03, "done");
        rdChk(ADDR_TX_STAT, 8'h03, 8'h01, "doneClr");
        wr(ADDR_CTRL, 8'h00);
        rdChk(ADDR_TX_STAT, 8'hFF, 8'h00, "statOff");
        // Half-code modes: upper half then lower half
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_TX_VALID, 8'h01);
            wr(ADDR_TX_DATA, 8'(i));
            fork
                checkTx(8'(i), 8'h01, 1, 32, 32 * (1 - i));
                wr(ADDR_CTRL, (i == 0) ? 8'hB0 : 8'hA0);
            join
            repeat (5) @(negedge sys_clk);
            chkBit("txActive", 1'b0, txActive);
            wr(ADDR_CTRL, 8'h00);
        end
        // Correlator with a half-ones code and steady input
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CODE_BASE + 6'(i), (i < 4) ? 8'hFF : 8'h00);
        end
        rxChipIn = 1'b1;
        wr(ADDR_CTRL, 8'h40);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_THR_LOW, T_LOW[i]);
            wr(ADDR_THR_HIGH, T_HIGH[i]);
            rxCheck(T_VAL[i], T_ERA[i]);
        end
        results();
    end
endmodule
